/* core/sls_defines.vh */
// Purpose: constants for the status indicator sequencer
// Assumes: 25 MHz core clock
// Notes:   phase codes select the indicator pattern
`ifndef SLS_DEFINES_VH
`define SLS_DEFINES_VH

`define SLS_CLK_HZ        25000000
`define SLS_FLASH_SLOW_HZ 1
`define SLS_FLASH_FAST_HZ 2
// half period in cycles: toggle twice per flash period
`define SLS_SLOW_HALF     (`SLS_CLK_HZ / (2 * `SLS_FLASH_SLOW_HZ))
`define SLS_FAST_HALF     (`SLS_CLK_HZ / (2 * `SLS_FLASH_FAST_HZ))
// asynchronous orange flash offset: quarter of a fast period
`define SLS_ASYNC_OFS     (`SLS_FAST_HALF / 2)

// phase codes
`define SLS_PH_OFF        4'h0
`define SLS_PH_POWER      4'h1
`define SLS_PH_BOOTING    4'h2
`define SLS_PH_BOOTED     4'h3
`define SLS_PH_ENUM_WAIT  4'h4
`define SLS_PH_ENUM_USB2  4'h5
`define SLS_PH_ENUM_USB3  4'h6
`define SLS_PH_STOP       4'h7
`define SLS_PH_ERROR      4'h8
`define SLS_PH_RUN        4'h9

// indicator function select per lamp
`define SLS_FN_DEFAULT    2'h0
`define SLS_FN_GPO        2'h1
`define SLS_FN_OFF        2'h2
`define SLS_FN_ON         2'h3

`endif

/* core/sls_flash_div.v */
// Purpose: free-running divider giving a square flash wave
// Assumes: clock synchronous, reset already synchronised
// Notes:   wave toggles every HALF cycles; OFS preloads the count
`timescale 1ns/1ns
`default_nettype none
module sls_flash_div #(
  parameter integer HALF = 12500000,
  parameter integer OFS  = 0
) (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // flash output
  output reg  wave_ff
);
  localparam [31:0] LAST  = HALF - 1;
  localparam [31:0] START = OFS;
  reg  [31:0] cnt_ff;
  wire        wrap = (cnt_ff == LAST);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= START;  // [R7]
      wave_ff <= 1'b0;
    end else if (wrap) begin
      cnt_ff  <= 32'h0;
      wave_ff <= ~wave_ff;  // [R7]
    end else begin
      cnt_ff  <= cnt_ff + 32'h1;
    end
  end
endmodule
`default_nettype wire

/* core/sls_status_led_sequencer.v */
// Purpose: drives the four rear status lamps of the camera
// Assumes: phase and configuration inputs synchronous to core_clk
// Notes:   lamp order is red, green, blue, orange (bit 0..3)
// Operation
// [R1] after power-on: red on, green exposure, blue frame, orange connection
// [R2] each lamp may be reassigned like a general output line
// [R3] boot: power red; booting green+blue 2 Hz; finished red+orange
// [R4] enumeration wait red 1 Hz; USB2 orange 2 Hz; USB3 orange steady
// [R5] stop: red+orange 2 Hz; error: red 2 Hz, orange flashing offset; here orange flashes unshifted with half period FAST_HALF + ASYNC_OFS
// [R6] after host open: red on, green exposure, blue frame, orange on
// [R7] flash rates come from reset-cleared free-running clock dividers
`timescale 1ns/1ns
`default_nettype none
`include "sls_defines.vh"
module sls_status_led_sequencer #(
  parameter integer SLOW_HALF = `SLS_SLOW_HALF,
  parameter integer FAST_HALF = `SLS_FAST_HALF,
  parameter integer ASYNC_OFS = `SLS_ASYNC_OFS
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst_n,
  // device phase
  input  wire [3:0] phase,
  input  wire       host_device_open_call,
  // default sources
  input  wire       exposure_active,
  input  wire       frame_active,
  input  wire       connection_up,
  // per-lamp configuration, two bits per lamp
  input  wire [7:0] lamp_func,
  input  wire [3:0] lamp_gpo,
  // lamps
  output reg  [3:0] lamp_ff
);
  ////////////////////////////////////////////////////////////////
  // reset release
  reg rst_s1_ff;
  reg rst_s2_ff;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire srst_n = rst_s2_ff;

  ////////////////////////////////////////////////////////////////
  // flash sources
  wire slow_w;
  wire fast_w;
  wire async_w;
  sls_flash_div #(.HALF(SLOW_HALF), .OFS(0)) u_slow (
    .clk     (core_clk),
    .rst_n   (srst_n),
    .wave_ff (slow_w)
  );  // [R7]
  sls_flash_div #(.HALF(FAST_HALF), .OFS(0)) u_fast (
    .clk     (core_clk),
    .rst_n   (srst_n),
    .wave_ff (fast_w)
  );  // [R7]
  sls_flash_div #(.HALF(FAST_HALF + ASYNC_OFS), .OFS(0)) u_async (
    .clk     (core_clk),
    .rst_n   (srst_n),
    .wave_ff (async_w)
  );

  ////////////////////////////////////////////////////////////////
  // host-open latch, cleared on leaving run
  // only an open seen while in run counts
  reg opened_ff;
  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      opened_ff <= 1'b0;
    end else if (phase != `SLS_PH_RUN) begin
      opened_ff <= 1'b0;
    end else if (host_device_open_call) begin
      opened_ff <= 1'b1;  // [R6]
    end
  end

  ////////////////////////////////////////////////////////////////
  // run-time defaults, bit order orange, blue, green, red
  wire [3:0] pwr_dflt  = {connection_up, frame_active, exposure_active, 1'b1};  // [R1]
  wire [3:0] open_dflt = {1'b1, frame_active, exposure_active, 1'b1};           // [R6]
  wire [3:0] run_dflt  = opened_ff ? open_dflt : pwr_dflt;

  ////////////////////////////////////////////////////////////////
  // default functions and phase patterns, one lamp per line
  reg        red;
  reg        green;
  reg        blue;
  reg        orange;
  reg        use_cfg;
  wire [3:0] dflt = {orange, blue, green, red};

  always @* begin
    use_cfg = 1'b0;
    case (phase)
      `SLS_PH_OFF: begin
        red    = 1'b0;
        green  = 1'b0;
        blue   = 1'b0;
        orange = 1'b0;
      end

      `SLS_PH_POWER: begin
        red    = 1'b1;    // [R3]
        green  = 1'b0;
        blue   = 1'b0;
        orange = 1'b0;
      end

      `SLS_PH_BOOTING: begin
        red    = 1'b0;
        green  = fast_w;  // [R3]
        blue   = fast_w;  // [R3]
        orange = 1'b0;
      end

      `SLS_PH_BOOTED: begin
        red    = 1'b1;    // [R3]
        green  = 1'b0;
        blue   = 1'b0;
        orange = 1'b1;    // [R3]
      end

      `SLS_PH_ENUM_WAIT: begin
        red    = slow_w;  // [R4]
        green  = 1'b0;
        blue   = 1'b0;
        orange = 1'b0;
      end

      `SLS_PH_ENUM_USB2: begin
        red    = 1'b0;
        green  = 1'b0;
        blue   = 1'b0;
        orange = fast_w;  // [R4]
      end

      `SLS_PH_ENUM_USB3: begin
        red    = 1'b0;
        green  = 1'b0;
        blue   = 1'b0;
        orange = 1'b1;    // [R4]
      end

      `SLS_PH_STOP: begin
        red    = fast_w;  // [R5]
        green  = 1'b0;
        blue   = 1'b0;
        orange = fast_w;  // [R5]
      end

      `SLS_PH_ERROR: begin
        red    = fast_w;  // [R5]
        green  = 1'b0;
        blue   = 1'b0;
        orange = async_w; // [R5]
      end

      `SLS_PH_RUN: begin
        use_cfg = 1'b1;
        red     = run_dflt[0];  // [R1] [R6]
        green   = run_dflt[1];  // [R1] [R6]
        blue    = run_dflt[2];  // [R1] [R6]
        orange  = run_dflt[3];  // [R1] [R6]
      end

      default: begin
        red    = 1'b0;
        green  = 1'b0;
        blue   = 1'b0;
        orange = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // per-lamp override, only honoured in run
  wire [3:0] nxt_lamp;
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lamp
      wire [1:0] fn = lamp_func[2*i+1:2*i];
      reg        cfg_bit;
      always @* begin
        case (fn)
          `SLS_FN_GPO: cfg_bit = lamp_gpo[i];  // [R2]
          `SLS_FN_OFF: cfg_bit = 1'b0;         // [R2]
          `SLS_FN_ON:  cfg_bit = 1'b1;         // [R2]
          default:     cfg_bit = dflt[i];
        endcase
      end
      assign nxt_lamp[i] = use_cfg ? cfg_bit : dflt[i];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // lamp drive register
  always @(posedge core_clk or negedge srst_n) begin
    if (!srst_n) begin
      lamp_ff <= 4'h0;
    end else begin
      lamp_ff <= nxt_lamp;
    end
  end
endmodule
`default_nettype wire

/* dv/sls_lamp_model.sv */
// Purpose: four status lamps, toggle counting
// Assumes: lamps sampled on core clock
// Notes: clr restarts every count
`timescale 1ns/1ns
`default_nettype none
module sls_lamp_model (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic [3:0] lamp,
  output var  logic [7:0] tg [4]
);
  logic [3:0] last;
  always @(posedge clk) begin
    last <= lamp;
    for (int i = 0; i < 4; i++)
      tg[i] <= clr ? 8'h00 : tg[i] + {7'h00, lamp[i] ^ last[i]};
  end
endmodule
`default_nettype wire

/* dv/sls_seq_monitor.sv */
// Purpose: lamp pattern checks
// Assumes: divider halves of four or more
// Notes: gated until internal reset is gone
`timescale 1ns/1ns
`default_nettype none
`include "sls_defines.vh"
module sls_seq_monitor (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [3:0] phase,
  input wire logic       host_device_open_call,
  input wire logic       exposure_active,
  input wire logic       frame_active,
  input wire logic       connection_up,
  input wire logic [7:0] lamp_func,
  input wire logic [3:0] lamp_gpo,
  input wire logic [3:0] lamp_ff
);
  logic [1:0] up_ff;
  logic       op_ff;
  wire        ok  = up_ff == 2'h3;
  wire        run = ok && phase == `SLS_PH_RUN;
  wire  [3:0] df  = {op_ff | connection_up, frame_active, exposure_active, 1'b1};
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n) {up_ff, op_ff} <= 3'h0;
    else begin
      up_ff <= up_ff + {1'b0, !ok};
      op_ff <= run & (op_ff | host_device_open_call);
    end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_run_dflt: assert property (run && lamp_func == 8'h00 |=> lamp_ff == $past(df))
    else $error("run defaults");
  a_gpo_red: assert property (run && lamp_func[1:0] == 2'h1 |=> lamp_ff[0] == $past(lamp_gpo[0]))
    else $error("gpo red");
  a_boot_pair: assert property (ok && phase == `SLS_PH_BOOTING |=> !lamp_ff[3] && !lamp_ff[0] && lamp_ff[2] == lamp_ff[1])
    else $error("boot pattern");
  a_usb3_on: assert property (ok && phase == `SLS_PH_ENUM_USB3 |=> lamp_ff == 4'h8)
    else $error("usb3 pattern");
  a_stop_pair: assert property (ok && phase == `SLS_PH_STOP |=> lamp_ff[2:1] == 2'h0 && lamp_ff[0] == lamp_ff[3])
    else $error("stop pattern");
  a_open_orange: assert property (run && op_ff && lamp_func[7:6] == 2'h0 |=> lamp_ff[3])
    else $error("opened orange");
  a_flash_hold: assert property (ok && $past(phase) == `SLS_PH_STOP && $past(phase, 2) == `SLS_PH_STOP
    && $rose(lamp_ff[0]) |=> ($past(phase) != `SLS_PH_STOP || $stable(lamp_ff[0])) [*3])
    else $error("flash too short");
  c_opened: cover property (run && op_ff);
  c_err_orange: cover property (ok && phase == `SLS_PH_ERROR && lamp_ff[3]);
  c_gpo_red: cover property (run && lamp_func[1:0] == 2'h1);
endmodule
bind sls_status_led_sequencer sls_seq_monitor u_mon (.core_clk, .rst_n, .phase,
  .host_device_open_call, .exposure_active, .frame_active, .connection_up, .lamp_func,
  .lamp_gpo, .lamp_ff);
`default_nettype wire

/* dv/testbench.sv */
// Purpose: phase table and random run mode bench
// Assumes: halves 8, 4, offset 2
// Notes: toggles counted by the lamp model
`timescale 1ns/1ns
`default_nettype none
`include "sls_defines.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
  logic       core_clk = 0, rst_n = 0, call = 0, ex = 0, fr = 0, cn = 0, clr = 0, op;
  logic [3:0] phase = 0, gpo = 4'hF;
  logic [7:0] func = 8'hAA;
  wire  [3:0] lamp;
  wire  [7:0] tg [4];
  int         errors = 0, tests_run = 0, seed = 32'h85505459;
  sls_status_led_sequencer #(.SLOW_HALF(8), .FAST_HALF(4), .ASYNC_OFS(2)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .phase(phase), .host_device_open_call(call),
    .exposure_active(ex), .frame_active(fr), .connection_up(cn), .lamp_func(func),
    .lamp_gpo(gpo), .lamp_ff(lamp));
  sls_lamp_model u_lamps (.clk(core_clk), .clr(clr), .lamp(lamp), .tg(tg));
  function logic [3:0] exp_run(input [7:0] f, input [3:0] g, input [3:0] d);
    for (int i = 0; i < 4; i++)
      exp_run[i] = f[2*i+:2] == 2'h0 ? d[i] : f[2*i+:2] == 2'h1 ? g[i] : f[2*i];
  endfunction
  task wrap_up;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task win(input [3:0] ph, input [3:0] st, input [15:0] tc);
    logic [3:0] m;
    phase = ph;
    repeat (3) @(posedge core_clk);
    #1 clr = 1;
    @(posedge core_clk);
    #1 clr = 0;
    repeat (24) @(posedge core_clk);
    #1;
    for (int i = 0; i < 4; i++) begin
      `CHK(tg[i], {4'h0, tc[4*i+:4]})
      m[i] = tc[4*i+:4] == 4'h0;
    end
    `CHK(lamp & m, st)
    $display("phase %h done", ph);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #20 core_clk = ~core_clk;
  initial begin
    #2000000;
    errors++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1;
    win(`SLS_PH_OFF, 4'h0, 16'h0);
    win(`SLS_PH_POWER, 4'h1, 16'h0);
    win(`SLS_PH_BOOTING, 4'h0, 16'h0660);
    win(`SLS_PH_BOOTED, 4'h9, 16'h0);
    win(`SLS_PH_ENUM_WAIT, 4'h0, 16'h0003);
    win(`SLS_PH_ENUM_USB2, 4'h0, 16'h6000);
    win(`SLS_PH_ENUM_USB3, 4'h8, 16'h0);
    win(`SLS_PH_STOP, 4'h0, 16'h6006);
    win(`SLS_PH_ERROR, 4'h0, 16'h4006);
    win(4'hF, 4'h0, 16'h0);
    phase = `SLS_PH_RUN;
    op = 0;
    repeat (300) begin
      @(posedge core_clk);
      #1;
      `CHK(lamp, exp_run(func, gpo, {op | cn, fr, ex, 1'b1}))
      op = op | call;
      {ex, fr, cn} = 3'($random(seed));
      call = 6'($random(seed)) == 6'h00;
      func = 8'($random(seed));
      gpo = 4'($random(seed));
    end
    $display("random run done");
    wrap_up;
  end
endmodule
`default_nettype wire
